/* dv/dec_counter_props.sv */
// checker on the ports of the counter top
// assumes one clock domain; bound below
module dec_counter_props
  import dec_pkg::*;
#(
  parameter int STEP_CYC = FILT_STEP_CYC // filter step
)(
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic             gate_src,
  input wire logic [CNT_W-1:0] evt_cnt1,
  input wire logic [CNT_W-1:0] evt_cnt2,
  input wire logic [CNT_W-1:0] gate_result,
  input wire logic             gate_done,
  input wire logic             gate_busy,
  input wire logic             level1,
  input wire logic             level2
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_CNT1_STEP: assert property ($changed(evt_cnt1) |->
    $rose(level1) && evt_cnt1 == 16'($past(evt_cnt1) + 16'h1)) else $error("cnt1 step");
  AST_CNT2_STEP: assert property ($changed(evt_cnt2) |->
    $rose(level2) && evt_cnt2 == 16'($past(evt_cnt2) + 16'h1)) else $error("cnt2 step");
  AST_LVL1_CNT: assert property ($rose(level1) |-> $changed(evt_cnt1))
    else $error("rise1 lost");
  AST_LVL2_CNT: assert property ($rose(level2) |-> $changed(evt_cnt2))
    else $error("rise2 lost");
  AST_DONE_PULSE: assert property (gate_done |=> !gate_done) else $error("done long");
  AST_DONE_END: assert property (gate_done |->
    $fell(gate_busy) && !(gate_src ? level2 : level1)) else $error("done not at fall");
  AST_BUSY_START: assert property ($rose(gate_busy) |-> (gate_src ? level2 : level1))
    else $error("busy not at rise");
  AST_HOLD: assert property (!gate_done |-> $stable(gate_result)) else $error("result moved");
  AST_RST_CLR: assert property ($rose(nrst) |-> evt_cnt1 == CNT_RST &&
    evt_cnt2 == CNT_RST && gate_result == CNT_RST) else $error("reset not clear");
  AST_ABORT: assert property (gate_busy && $changed(gate_src) |-> ##[0:2] !gate_busy)
    else $error("no abort");
endmodule : dec_counter_props
bind dec_counter dec_counter_props #(.STEP_CYC(STEP_CYC)) u_props (.sys_clk, .nrst,
  .gate_src, .evt_cnt1, .evt_cnt2, .gate_result, .gate_done, .gate_busy, .level1, .level2);

/* dv/dec_counter_test.sv */
// self-checking bench for the counter top
// assumes dec_sensor drives both field inputs
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module dec_counter_test;
  import dec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, gate_src, in1, in2, go1, go2, busy1, busy2, got;
  logic [TB_SEL_W-1:0] tb_sel;
  logic [FILT_STEPS_W-1:0] filt_steps;
  logic [CNT_W-1:0] evt_cnt1, evt_cnt2, gate_result, hi1, hi2, res;
  logic gate_done, gate_busy, level1, level2;
  logic [31:0] rnd;
  int mismatches, cmp_count, e1, e2, er, k;
  int exp_q[$]; // expected gate results, oldest first
  dec_counter #(.STEP_CYC(4)) dut (.sys_clk, .nrst, .in1, .in2, .gate_src, .tb_sel,
    .filt_steps, .evt_cnt1, .evt_cnt2, .gate_result, .gate_done, .gate_busy, .level1, .level2);
  dec_sensor s1 (.sys_clk, .go(go1), .hi_cyc(hi1), .pin(in1), .busy(busy1));
  dec_sensor s2 (.sys_clk, .go(go2), .hi_cyc(hi2), .pin(in2), .busy(busy2));
  initial begin sys_clk = 0; forever #50 sys_clk = ~sys_clk; end
  initial begin repeat (80000) @(posedge sys_clk); mismatches++; close_out; end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // one pulse per masked input; flip aborts the gate at that cycle
  task automatic run(input int msk, input int flip, input int h1, input int h2);
    int n, f, d, ts;
    f = ((filt_steps > FILT_MAX_STEPS) ? FILT_MAX_STEPS : int'(filt_steps)) * 4;
    ts = (tb_sel > TB_RATES - 1) ? TB_RATES - 1 : int'(tb_sel);
    @(negedge sys_clk) {hi1, hi2, go1, go2} = {16'(h1), 16'(h2), msk[0], msk[1]};
    @(negedge sys_clk) {go1, go2} = 2'b00;
    d = (gate_src ? msk[1] : msk[0]) && flip < 0 && (gate_src ? h2 : h1) > f;
    if (d) exp_q.push_back((gate_src ? h2 : h1) >> ts);
    e1 += msk[0] && h1 > f;
    e2 += msk[1] && h2 > f;
    got = 0;
    res = gate_result;
    for (n = 0; (busy1 || busy2) && n < 4000; n++)
    begin
      @(negedge sys_clk);
      if (n == flip) gate_src = ~gate_src;
      if (gate_done === 1'b1) {got, res} = {1'b1, gate_result};
    end
    `CHK(n < 4000, 1'b1)
    `CHK(got, 1'(d))
    `CHK(evt_cnt1, 16'(e1))
    `CHK(evt_cnt2, 16'(e2))
    if (exp_q.size() > 0) er = exp_q.pop_front();
    `CHK(int'(res) - er <= 1 && er - int'(res) <= 1, 1'b1)
  endtask : run
  task automatic do_reset;
    nrst = 0;
    repeat (8) @(negedge sys_clk);
    nrst = 1;
    {e1, e2, er} = 0;
    exp_q.delete();
    repeat (4) @(negedge sys_clk);
    `CHK({evt_cnt1, evt_cnt2, gate_result, gate_busy}, 49'h0)
  endtask : do_reset
  initial
  begin
    {nrst, gate_src, go1, go2, tb_sel, filt_steps, hi1, hi2} = 0;
    rnd = 32'h0551;
    do_reset;
    for (k = 0; k < 9; k++)
    begin
      rnd = lfsr(rnd);
      @(negedge sys_clk) {gate_src, tb_sel} = {k[0] ^ rnd[20], 4'(k)};
      run(k % 3 + 1, -1, 200 + rnd[8:0], 200 + rnd[17:9]);
    end
    @(negedge sys_clk) {gate_src, tb_sel, filt_steps} = {1'b0, 4'h2, 7'h64};
    run(1, -1, 300, 0);
    run(3, -1, 450, 390);
    @(negedge sys_clk) filt_steps = 0;
    run(1, 400, 800, 0);
    `CHK(gate_result, res)
    do_reset;
    @(negedge sys_clk) {tb_sel, filt_steps} = {4'hf, 7'h7f};
    run(2, -1, 0, 600);
    close_out;
  end
endmodule : dec_counter_test

/* dv/dec_sensor.sv */
// field sensor model: one square pulse per request
// assumes requests are sampled on the rising edge of sys_clk
module dec_sensor #(
  parameter int MIN_HI = 200, // 20 us at 100 ns
  parameter int MIN_LO = 1000 // 100 us pause
)(
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [15:0] hi_cyc,
  output logic             pin,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  initial busy = 1'b0;
  // pulse high, then a full pause before done
  always
  begin
    @(posedge sys_clk iff go);
    busy = 1'b1;
    @(negedge sys_clk);
    pin = 1'b1;
    repeat ((int'(hi_cyc) < MIN_HI) ? MIN_HI : int'(hi_cyc)) @(negedge sys_clk);
    pin = 1'b0;
    repeat (MIN_LO) @(negedge sys_clk);
    busy = 1'b0;
  end
endmodule : dec_sensor

/* verilog/dec_chan_if.sv */
// carrier of one filtered input channel between the filter and the counters
// assumes both ends run on sys_clk
interface dec_chan_if;
  logic level; // filtered input level
  logic rise;  // one-cycle pulse on accepted rising edge
  logic fall;  // one-cycle pulse on accepted falling edge
  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface : dec_chan_if

/* verilog/dec_counter.sv */
// two event counters and one gate measurement unit behind two field inputs
// assumes field pins are asynchronous and config inputs are stable on sys_clk
//
// Functional notes
// - one 16-bit wrapping rising-edge counter per input
// - one gate unit, source input one or two
// - gate times rising edge to following falling edge
// - gate counts one of nine halving time bases
// - input filter 0-25 ms in 0.2 ms steps
module dec_counter
  import dec_pkg::*;
#(
  parameter int STEP_CYC = FILT_STEP_CYC // cycles per 0.2 ms filter step
)(
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    in1,
  input  wire logic                    in2,
  input  wire logic                    gate_src,
  input  wire logic [TB_SEL_W-1:0]     tb_sel,
  input  wire logic [FILT_STEPS_W-1:0] filt_steps,
  output logic      [CNT_W-1:0]        evt_cnt1,
  output logic      [CNT_W-1:0]        evt_cnt2,
  output logic      [CNT_W-1:0]        gate_result,
  output logic                         gate_done,
  output logic                         gate_busy,
  output logic                         level1,
  output logic                         level2
);
  if (STEP_CYC < 1) begin : g_chk
    $error("dec_counter: STEP_CYC must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input filters
  // each pin has its own synchroniser and filter; the step setting is
  // shared, so both inputs always see the same filter time
  dec_chan_if ch1 ();
  dec_chan_if ch2 ();

  dec_in_filter #(.STEP_CYC(STEP_CYC)) u_f1 (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (in1),
    .steps   (filt_steps),
    .ch      (ch1)
  );

  dec_in_filter #(.STEP_CYC(STEP_CYC)) u_f2 (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (in2),
    .steps   (filt_steps),
    .ch      (ch2)
  );

  // enable of the selected time base rate
  function automatic logic tb_tick(input logic [TB_DIV_W-1:0] div,
                                   input logic [TB_SEL_W-1:0] sel);
    logic [TB_DIV_W-1:0] mask;
    logic [TB_SEL_W-1:0] s;
    s    = (sel > TB_SEL_W'(TB_RATES - 1)) ? TB_SEL_W'(TB_RATES - 1) : sel;
    mask = TB_DIV_W'((9'h001 << s) - 9'h001);
    return (div & mask) == mask;
  endfunction : tb_tick

  ////////////////////////////////////////////////////////////////////////////
  // event counters
  // counters wrap silently; readers take differences modulo 2^16
  logic [CNT_W-1:0] next_evt1;
  logic [CNT_W-1:0] next_evt2;

  // count accepted rising edges, wrapping at 16 bits
  always_comb
  begin
    next_evt1 = evt_cnt1;
    next_evt2 = evt_cnt2;
    if (ch1.rise)
    begin
      next_evt1 = evt_cnt1 + CNT_W'(1);
    end
    if (ch2.rise)
    begin
      next_evt2 = evt_cnt2 + CNT_W'(1);
    end
  end

  // registers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      evt_cnt1 <= CNT_RST;
      evt_cnt2 <= CNT_RST;
    end
    else
    begin
      evt_cnt1 <= next_evt1;
      evt_cnt2 <= next_evt2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base divider
  // free-runs from reset, so the first tick of a measurement may fall
  // anywhere in its period: a result is good to within one tick
  logic [TB_DIV_W-1:0] div;
  logic [TB_DIV_W-1:0] next_div;
  logic                tb_en;

  // free running divider, halving per select step
  always_comb
  begin
    next_div = div + TB_DIV_W'(1);
    tb_en    = tb_tick(div, tb_sel);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      div <= DIV_RST;
    end
    else
    begin
      div <= next_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate measurement
  // a source switch while timing drops the pulse rather than mixing the
  // edges of two inputs; the last good result stays on gate_result
  dec_gate_e        st;          // gate state
  dec_gate_e        next_st;
  logic [CNT_W-1:0] gcnt;        // running gate count
  logic [CNT_W-1:0] next_gcnt;
  logic [CNT_W-1:0] next_result;
  logic             next_done;
  logic             next_busy;   // busy level for next cycle
  logic             src_q;       // source seen last cycle
  logic             g_rise;      // selected edges
  logic             g_fall;

  // pulse timing state machine
  always_comb
  begin
    g_rise      = gate_src ? ch2.rise : ch1.rise;
    g_fall      = gate_src ? ch2.fall : ch1.fall;
    next_st     = st;
    next_gcnt   = gcnt;
    next_result = gate_result;
    next_done   = 1'b0;
    case (st)
      GM_IDLE:
      begin
        // wait for rising edge of the source
        if (g_rise)
        begin
          next_st   = GM_RUN;
          next_gcnt = CNT_RST;
        end
      end
      GM_RUN:
      begin
        if (src_q != gate_src)
        begin
          // source switched mid pulse: drop it
          next_st = GM_IDLE;
        end
        else if (g_fall)
        begin
          // pulse ended: publish and hold result
          next_st     = GM_IDLE;
          next_result = gcnt;
          next_done   = 1'b1;
        end
        else if (tb_en && gcnt != {CNT_W{1'b1}})
        begin
          // saturate so an overlong pulse reads as full scale
          next_gcnt = gcnt + CNT_W'(1);
        end
      end
      default:
      begin
        next_st = GM_IDLE;
      end
    endcase
    // busy follows the state that the machine is about to enter,
    // so it rises and falls in the same cycle as the state itself
    next_busy = (next_st == GM_RUN);
  end

  // registers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      st          <= GM_IDLE;
      gcnt        <= CNT_RST;
      gate_result <= CNT_RST;
      gate_done   <= 1'b0;
      gate_busy   <= 1'b0;
      src_q       <= 1'b0;
      level1      <= 1'b0;
      level2      <= 1'b0;
    end
    else
    begin
      st          <= next_st;
      gcnt        <= next_gcnt;
      gate_result <= next_result;
      gate_done   <= next_done;
      gate_busy   <= next_busy;
      src_q       <= gate_src;
      level1      <= ch1.level;
      level2      <= ch2.level;
    end
  end
endmodule : dec_counter

/* verilog/dec_in_filter.sv */
// input synchroniser and software filter for one field input
// assumes an asynchronous pin input and a step setting held by the system
module dec_in_filter
  import dec_pkg::*;
#(
  parameter int STEP_CYC = FILT_STEP_CYC, // cycles per filter step
  parameter int FILT_W   = 18             // width of the settle counter
)(
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    pin,
  input  wire logic [FILT_STEPS_W-1:0] steps,
  dec_chan_if.src                      ch
);
  // refuse a counter too narrow for the longest filter
  if (FILT_MAX_STEPS * STEP_CYC >= 2 ** FILT_W) begin : g_chk
    $error("dec_in_filter: FILT_W too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]        sync;        // three-stage pin synchroniser
  logic [2:0]        next_sync;   // next synchroniser value
  logic              lvl;         // accepted level
  logic              next_lvl;
  logic              rise_q;      // edge pulses
  logic              next_rise;
  logic              fall_q;
  logic              next_fall;
  logic [FILT_W-1:0] cnt;         // time the new level has stood
  logic [FILT_W-1:0] next_cnt;
  logic [FILT_W-1:0] limit;       // cycles needed to accept a change
  logic [FILT_STEPS_W-1:0] st;    // clamped step setting

  ////////////////////////////////////////////////////////////////////////////
  // settle logic: a change counts once stages two and three agree
  always_comb
  begin
    st = (steps > FILT_STEPS_W'(FILT_MAX_STEPS)) ? FILT_STEPS_W'(FILT_MAX_STEPS) : steps;
    limit     = FILT_W'(st) * FILT_W'(STEP_CYC);
    next_sync = {sync[1:0], pin};
    next_lvl  = lvl;
    next_cnt  = cnt;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (sync[1] != sync[2] || sync[2] == lvl)
    begin
      // unsettled or no change: restart the filter time
      next_cnt = '0;
    end
    else if (cnt >= limit)
    begin
      // change stood long enough: accept it
      next_lvl  = sync[2];
      next_rise = sync[2];
      next_fall = ~sync[2];
      next_cnt  = '0;
    end
    else
    begin
      next_cnt = cnt + FILT_W'(1);
    end
  end

  // registers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      sync   <= 3'h0;
      lvl    <= 1'b0;
      cnt    <= '0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      sync   <= next_sync;
      lvl    <= next_lvl;
      cnt    <= next_cnt;
      rise_q <= next_rise;
      fall_q <= next_fall;
    end
  end

  assign ch.level = lvl;
  assign ch.rise  = rise_q;
  assign ch.fall  = fall_q;
endmodule : dec_in_filter

/* verilog/dec_pkg.sv */
// constants shared by the dual event counter and gate measurement block
// assumes a single 10 MHz system clock and a synchronous active-low reset
package dec_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;         // sys_clk period
  localparam int FILT_STEP_NS  = 200000;      // one filter step, 0.2 ms
  localparam int FILT_STEP_CYC = FILT_STEP_NS / CLK_PERIOD_NS; // cycles per step
  localparam int FILT_MAX_MS   = 25;          // longest filter time
  localparam int FILT_MAX_STEPS = (FILT_MAX_MS * 1000000) / FILT_STEP_NS; // 125
  localparam int FILT_STEPS_W  = 7;           // width of the step setting
  ////////////////////////////////////////////////////////////////////////////
  // counters and time base
  localparam int CNT_W         = 16;          // event and gate counter width
  localparam int TB_RATES      = 9;           // selectable time base rates
  localparam int TB_SEL_W      = 4;           // width of the rate select
  localparam int TB_DIV_W      = TB_RATES - 1; // divider width, 2^8 slowest
  localparam int NUM_CH        = 2;           // input channels
  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CNT_W-1:0]    CNT_RST = 16'h0000;
  localparam logic [TB_DIV_W-1:0] DIV_RST = 8'h00;
  // gate measurement states
  typedef enum logic [0:0] {GM_IDLE, GM_RUN} dec_gate_e;
endpackage : dec_pkg
